// ---- rtl/dinmap_top.sv ----
//Contract
//RULE1 - four general and two dual-purpose terminals, each with a selectable function
//RULE2 - dual terminals act as pulse input or ordinary digital input
//RULE3 - software must not give two terminals one code; duplicate flags invalid
//RULE4 - code 0 terminals never produce any action
//RULE5 - codes 1 and 2 command forward and reverse running
//RULE6 - code 3 selects three-wire run control mode
//RULE7 - codes 4 and 5 command forward and reverse jogging
//RULE8 - code 6 blocks output at once for a coast stop
//RULE9 - code 7 is an external fault reset like the stop key
//RULE10 - code 8 pauses running, keeps state, resumes on release
//RULE11 - code 9 raises an external fault alarm and stops
//RULE12 - codes 10 and 11 raise and lower the terminal frequency setting
//RULE13 - code 12 clears the accumulated up/down frequency value
//RULE14 - code 13 switches reference between source A and source B
//RULE15 - codes 14 and 15 switch combined channel against A or B
//RULE16 - codes 16 to 19 form a four-bit preset speed selector
//RULE17 - each terminal passes two flip-flops before decoding
`timescale 1ns/10ps
`default_nettype none
module dinmap_top (
  // clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [11:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // terminal pins
  input  wire logic [dinmap_pkg::NUM_TERM-1:0] term_pin,
  // drive commands
  output dinmap_pkg::drive_cmd_t               drive_cmd,
  output logic                                 cfg_invalid,
  output logic      [dinmap_pkg::NUM_DUAL-1:0] pulse_sel,
  output logic      [dinmap_pkg::NUM_DUAL-1:0] pulse_raw,
  output logic                                 irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [dinmap_pkg::NUM_TERM-1:0][dinmap_pkg::CODE_W-1:0] func;
    logic [dinmap_pkg::NUM_DUAL-1:0]                         dual;
    logic [dinmap_pkg::IRQ_W-1:0]                            irq_st;
    logic [dinmap_pkg::IRQ_W-1:0]                            irq_msk;
    dinmap_pkg::drive_cmd_t                                  cmd;
    logic                                                    bad;
    logic [dinmap_pkg::NUM_DUAL-1:0]                         praw;
    logic [dinmap_pkg::NUM_DUAL-1:0]                         psel_o;
    logic [31:0]                                             rdata;
    logic                                                    ready;
    logic                                                    err;
    logic                                                    irq;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  logic [dinmap_pkg::NUM_TERM-1:0] term_sync;
  logic [dinmap_pkg::NUM_TERM-1:0] term_dig;
  logic [dinmap_pkg::NUM_TERM-1:0][dinmap_pkg::CODE_W-1:0] eff_code;
  logic [31:0]                     code_hit;
  logic [31:0]                     code_cnt_dup;
  logic                            dup;
  dinmap_pkg::drive_cmd_t          dec;
  logic                            setup;
  logic                            wr;
  logic                            rd_ok;
  logic [31:0]                     rd_val;
  logic [dinmap_pkg::IRQ_W-1:0]    ev;

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser

  // RULE17 two stage sync
  dinmap_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (term_pin),
    .pin_sync (term_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // terminal mapping

  // RULE1 six terminals mapped
  // RULE2 dual terminals pulse or digital
  genvar gi;
  generate
    for (gi = 0; gi < dinmap_pkg::NUM_TERM; gi++) begin : g_term
      if (gi >= dinmap_pkg::NUM_GEN) begin : g_dual
        assign term_dig[gi] = term_sync[gi] & ~st_ff.dual[gi-dinmap_pkg::NUM_GEN];
        assign eff_code[gi] = st_ff.dual[gi-dinmap_pkg::NUM_GEN] ? dinmap_pkg::FN_NONE : st_ff.func[gi];
      end else begin : g_gen
        assign term_dig[gi] = term_sync[gi];
        assign eff_code[gi] = st_ff.func[gi];
      end
    end
  endgenerate

  always_comb begin
    code_hit     = '0;
    code_cnt_dup = '0;
    dec          = '0;
    for (int i = 0; i < dinmap_pkg::NUM_TERM; i++) begin
      // RULE3 duplicate code detect
      if (eff_code[i] != dinmap_pkg::FN_NONE) begin
        if (code_hit[eff_code[i]]) begin
          code_cnt_dup[eff_code[i]] = 1'b1;
        end
        code_hit[eff_code[i]] = 1'b1;
      end
      // RULE4 code zero ignored
      if (term_dig[i] && eff_code[i] != dinmap_pkg::FN_NONE) begin
        case (eff_code[i])
          // RULE5 run direction
          dinmap_pkg::FN_FWD: begin
            dec.forward_run_cmd = 1'b1;
          end
          dinmap_pkg::FN_REV: begin
            dec.reverse_run_cmd = 1'b1;
          end
          // RULE6 three wire mode
          dinmap_pkg::FN_3WIRE: begin
            dec.three_wire = 1'b1;
          end
          // RULE7 jog commands
          dinmap_pkg::FN_JOGF: begin
            dec.jog_fwd = 1'b1;
          end
          dinmap_pkg::FN_JOGR: begin
            dec.jog_rev = 1'b1;
          end
          // RULE8 coast stop
          dinmap_pkg::FN_COAST: begin
            dec.coast_stop = 1'b1;
          end
          // RULE9 fault reset
          dinmap_pkg::FN_FRST: begin
            dec.fault_reset = 1'b1;
          end
          // RULE10 running pause level
          dinmap_pkg::FN_PAUSE: begin
            dec.run_pause = 1'b1;
          end
          // RULE11 external fault
          dinmap_pkg::FN_EXTF: begin
            dec.ext_fault = 1'b1;
          end
          // RULE12 frequency up down
          dinmap_pkg::FN_UP: begin
            dec.freq_up = 1'b1;
          end
          dinmap_pkg::FN_DOWN: begin
            dec.freq_down = 1'b1;
          end
          // RULE13 up down clear
          dinmap_pkg::FN_UDCLR: begin
            dec.updown_clr = 1'b1;
          end
          // RULE14 source a b switch
          dinmap_pkg::FN_SWAB: begin
            dec.sw_ab = 1'b1;
          end
          // RULE15 combined channel switch
          dinmap_pkg::FN_SWCA: begin
            dec.sw_comb_a = 1'b1;
          end
          dinmap_pkg::FN_SWCB: begin
            dec.sw_comb_b = 1'b1;
          end
          default: begin
            // RULE16 step selector bits
            if (eff_code[i] >= dinmap_pkg::FN_STEP0 && eff_code[i] <= dinmap_pkg::FN_MAX) begin
              dec.step_sel[eff_code[i][1:0]] = 1'b1;
            end
          end
        endcase
      end
    end
    dup = |code_cnt_dup;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign setup = psel & ~penable;
  assign wr    = setup & pwrite;

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = '0;
    if (paddr[1:0] != 2'h0) begin
      rd_ok = 1'b0;
    end else if (paddr <= dinmap_pkg::OFF_FUNC5) begin
      rd_val = {27'h0, st_ff.func[paddr[4:2]]};
    end else begin
      case (paddr)
        dinmap_pkg::OFF_DUALCFG: begin
          rd_val = {30'h0, st_ff.dual};
        end
        dinmap_pkg::OFF_STATUS: begin
          rd_val = {25'h0, st_ff.bad, term_sync};
        end
        dinmap_pkg::OFF_IRQST: begin
          rd_val = {28'h0, st_ff.irq_st};
        end
        dinmap_pkg::OFF_IRQMSK: begin
          rd_val = {28'h0, st_ff.irq_msk};
        end
        dinmap_pkg::OFF_CMD: begin
          rd_val = {13'h0, st_ff.cmd};
        end
        default: begin
          rd_ok = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    ev                      = '0;
    ev[dinmap_pkg::IRQ_EXTF]   = dec.ext_fault & ~st_ff.cmd.ext_fault;
    ev[dinmap_pkg::IRQ_FRST]   = dec.fault_reset & ~st_ff.cmd.fault_reset;
    ev[dinmap_pkg::IRQ_CFGBAD] = dup & ~st_ff.bad;
    ev[dinmap_pkg::IRQ_COAST]  = dec.coast_stop & ~st_ff.cmd.coast_stop;
    nxt_st       = st_ff;
    nxt_st.ready = setup;
    nxt_st.err   = setup & ~rd_ok;
    nxt_st.rdata = (setup & ~pwrite & rd_ok) ? rd_val : 32'h0;
    if (wr && rd_ok) begin
      if (paddr <= dinmap_pkg::OFF_FUNC5) begin
        nxt_st.func[paddr[4:2]] = pwdata[dinmap_pkg::CODE_W-1:0];
      end else if (paddr == dinmap_pkg::OFF_DUALCFG) begin
        nxt_st.dual = pwdata[dinmap_pkg::NUM_DUAL-1:0];
      end else if (paddr == dinmap_pkg::OFF_IRQST) begin
        nxt_st.irq_st = st_ff.irq_st & ~pwdata[dinmap_pkg::IRQ_W-1:0];
      end else if (paddr == dinmap_pkg::OFF_IRQMSK) begin
        nxt_st.irq_msk = pwdata[dinmap_pkg::IRQ_W-1:0];
      end
    end
    // set wins over clear
    nxt_st.irq_st = nxt_st.irq_st | ev;
    // RULE3 invalid config clears all commands except a forced coast stop
    nxt_st.bad    = dup;
    nxt_st.cmd    = dup ? '0 : dec;
    if (dup) begin
      nxt_st.cmd.coast_stop = 1'b1;
    end
    nxt_st.praw   = term_sync[dinmap_pkg::NUM_TERM-1:dinmap_pkg::NUM_GEN] & st_ff.dual;
    nxt_st.psel_o = st_ff.dual;
    nxt_st.irq    = |(nxt_st.irq_st & st_ff.irq_msk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata      = st_ff.rdata;
  assign pready      = st_ff.ready;
  assign pslverr     = st_ff.err;
  assign drive_cmd   = st_ff.cmd;
  assign cfg_invalid = st_ff.bad;
  assign pulse_sel   = st_ff.psel_o;
  assign pulse_raw   = st_ff.praw;
  assign irq         = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_zero_code_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (st_ff.func == '0 && !st_ff.bad) |=> (drive_cmd == '0))
    else $error("code zero produced a command");

  a_fwd_follows_pin: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (eff_code[0] == dinmap_pkg::FN_FWD && term_dig[0] && !dup) |=> drive_cmd.forward_run_cmd)
    else $error("forward run not driven");

  a_coast_on_fault: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    dup |=> (drive_cmd.coast_stop && !drive_cmd.forward_run_cmd && !drive_cmd.reverse_run_cmd))
    else $error("coast not forced on bad config");

  a_extf_sets_irq: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    $rose(drive_cmd.ext_fault) |-> st_ff.irq_st[dinmap_pkg::IRQ_EXTF])
    else $error("external fault not latched");

  a_dup_flags_bad: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    dup |=> cfg_invalid)
    else $error("duplicate code not flagged");

  a_dup_sets_irq: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    (dup && !st_ff.bad) |=> st_ff.irq_st[dinmap_pkg::IRQ_CFGBAD])
    else $error("duplicate code not latched");

  a_dual_blocks_dig: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    st_ff.dual[0] |-> (eff_code[dinmap_pkg::NUM_GEN] == dinmap_pkg::FN_NONE))
    else $error("pulse terminal still decoded");

  a_sync_latency: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    ##2 (term_sync == $past(term_pin, 2)))
    else $error("sync latency wrong");

  a_step_bit0: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    (eff_code[1] == dinmap_pkg::FN_STEP0 && term_dig[1] && !dup) |=> drive_cmd.step_sel[0])
    else $error("step bit zero missing");

  a_pause_level: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (!dup && !dec.run_pause) |=> !drive_cmd.run_pause)
    else $error("pause held without input");

  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    (st_ff.irq_msk == '0) [*2] |-> !irq)
    else $error("masked interrupt raised");

  a_pulse_raw_gated: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    !st_ff.dual[0] |=> !pulse_raw[0])
    else $error("pulse path open in digital mode");

  a_coast_follows: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    dec.coast_stop |=> drive_cmd.coast_stop)
    else $error("coast stop not driven");

  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (psel && !penable) |=> (pready ##1 !pready))
    else $error("register answer not one cycle");

endmodule
`default_nettype wire

// ---- inc/dinmap_pkg.sv ----
package dinmap_pkg;

  // terminal counts
  localparam int NUM_GEN   = 4;
  localparam int NUM_DUAL  = 2;
  localparam int NUM_TERM  = 6;
  localparam int CODE_W    = 5;
  localparam int TERM_W    = 3;

  // register byte offsets
  localparam logic [11:0] OFF_FUNC0   = 12'h000;
  localparam logic [11:0] OFF_FUNC5   = 12'h014;
  localparam logic [11:0] OFF_DUALCFG = 12'h018;
  localparam logic [11:0] OFF_STATUS  = 12'h01c;
  localparam logic [11:0] OFF_IRQST   = 12'h020;
  localparam logic [11:0] OFF_IRQMSK  = 12'h024;
  localparam logic [11:0] OFF_CMD     = 12'h028;

  // function codes
  localparam logic [4:0] FN_NONE     = 5'h00;
  localparam logic [4:0] FN_FWD      = 5'h01;
  localparam logic [4:0] FN_REV      = 5'h02;
  localparam logic [4:0] FN_3WIRE    = 5'h03;
  localparam logic [4:0] FN_JOGF     = 5'h04;
  localparam logic [4:0] FN_JOGR     = 5'h05;
  localparam logic [4:0] FN_COAST    = 5'h06;
  localparam logic [4:0] FN_FRST     = 5'h07;
  localparam logic [4:0] FN_PAUSE    = 5'h08;
  localparam logic [4:0] FN_EXTF     = 5'h09;
  localparam logic [4:0] FN_UP       = 5'h0a;
  localparam logic [4:0] FN_DOWN     = 5'h0b;
  localparam logic [4:0] FN_UDCLR    = 5'h0c;
  localparam logic [4:0] FN_SWAB     = 5'h0d;
  localparam logic [4:0] FN_SWCA     = 5'h0e;
  localparam logic [4:0] FN_SWCB     = 5'h0f;
  localparam logic [4:0] FN_STEP0    = 5'h10;
  localparam logic [4:0] FN_MAX      = 5'h13;

  // reset values
  localparam logic [4:0] FUNC_RST    = 5'h00;
  localparam logic [1:0] DUAL_RST    = 2'h0;
  localparam logic [3:0] IRQ_RST     = 4'h0;

  // interrupt status bits
  localparam int IRQ_EXTF   = 0;
  localparam int IRQ_FRST   = 1;
  localparam int IRQ_CFGBAD = 2;
  localparam int IRQ_COAST  = 3;
  localparam int IRQ_W      = 4;

  // command bus bit fields
  typedef struct packed {
    logic       forward_run_cmd;
    logic       reverse_run_cmd;
    logic       three_wire;
    logic       jog_fwd;
    logic       jog_rev;
    logic       coast_stop;
    logic       fault_reset;
    logic       run_pause;
    logic       ext_fault;
    logic       freq_up;
    logic       freq_down;
    logic       updown_clr;
    logic       sw_ab;
    logic       sw_comb_a;
    logic       sw_comb_b;
    logic [3:0] step_sel;
  } drive_cmd_t;

  localparam int CMD_W = 19;

endpackage

// ---- rtl/dinmap_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module dinmap_sync (
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // pins in, synchronised out
  input  wire logic [dinmap_pkg::NUM_TERM-1:0] pin_in,
  output logic      [dinmap_pkg::NUM_TERM-1:0] pin_sync
);

  typedef struct packed {
    logic [dinmap_pkg::NUM_TERM-1:0] meta;
    logic [dinmap_pkg::NUM_TERM-1:0] sync;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = pin_in;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_sync = st_ff.sync;

endmodule
`default_nettype wire

// ---- tb/dinmap_switch_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dinmap_switch_model (
  // clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // requested contact levels
  input  wire logic [dinmap_pkg::NUM_TERM-1:0] want,
  input  wire logic                            slow,
  // terminal levels
  output logic      [dinmap_pkg::NUM_TERM-1:0] term_pin
);
  logic [dinmap_pkg::NUM_TERM-1:0] stage_ff;
  //////////////////////////////////////////////////////////////////
  // contacts settle one cycle later in slow mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_ff <= '0;
      term_pin <= '0;
    end else begin
      stage_ff <= want;
      term_pin <= slow ? stage_ff : want;
    end
  end
endmodule
`default_nettype wire

// ---- tb/digital_input_function_map_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module digital_input_function_map_tb;
  typedef struct packed {logic rd; logic err; logic [31:0] data;} apb_exp_t;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                   cfg_invalid, irq, slow;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rng, ev;
  logic [5:0]             want, term_pin;
  logic [3:0]             p;
  logic [1:0]             pulse_sel, pulse_raw;
  dinmap_pkg::drive_cmd_t drive_cmd;
  apb_exp_t               exp_q[$];
  apb_exp_t               e;
  int                     err_total, samples_checked, t;
  //////////////////////////////////////////////////////////////////
  dinmap_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .term_pin(term_pin), .drive_cmd(drive_cmd),
    .cfg_invalid(cfg_invalid), .pulse_sel(pulse_sel), .pulse_raw(pulse_raw), .irq(irq));
  dinmap_switch_model sw (.pclk(pclk), .presetn(presetn), .want(want), .slow(slow),
    .term_pin(term_pin));
  always #5 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [11:0] fa(input int i);
    return dinmap_pkg::OFF_FUNC0 + 12'(4 * i);
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] x);
    samples_checked++;
    if (seen !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, x, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic er);
    int n = 0;
    exp_q.push_back('{!w, er, x});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("apb_wait", 32'h1, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, x, 1'b0);
  endtask
  task automatic set_pins(input logic [5:0] v, input logic s);
    @(posedge pclk);
    want <= v;
    slow <= s;
  endtask
  task automatic expect_cmd(input logic [18:0] x);
    int n = 0;
    while (drive_cmd !== x && n < 12) begin
      @(negedge pclk);
      n++;
    end
    check("drive_cmd", 32'(drive_cmd), 32'(x));
  endtask
  task automatic settle();
    repeat (5) @(negedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////
  // monitor: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("apb_extra", 32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        check("pslverr", 32'(pslverr), 32'(e.err));
        if (e.rd) check("prdata", prdata, e.data);
      end
    end
  end
  initial begin
    #100000;
    check("watchdog", 32'h1, 32'h0);
    print_verdict();
  end
  //////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, slow} = '0;
    {paddr, pwdata, want} = '0;
    rng = 32'hf6b7;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("drive_cmd_rst", 32'(drive_cmd), 32'h0);
    for (int i = 0; i < 6; i++) rd(fa(i), 32'(dinmap_pkg::FUNC_RST));
    rd(dinmap_pkg::OFF_DUALCFG, 32'(dinmap_pkg::DUAL_RST));
    rd(dinmap_pkg::OFF_IRQMSK, 32'(dinmap_pkg::IRQ_RST));
    apb(1'b0, 12'h030, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h002, 32'h5, 32'h0, 1'b1);
    rd(fa(0), 32'h0);
    // code 0 and out-of-range codes stay silent
    wr(fa(1), 32'h14);
    wr(fa(2), 32'h1f);
    set_pins(6'h3f, 1'b0);
    settle();
    check("idle_cmd", 32'(drive_cmd), 32'h0);
    set_pins(6'h00, 1'b0);
    wr(fa(1), 32'h0);
    wr(fa(2), 32'h0);
    wr(dinmap_pkg::OFF_IRQMSK, 32'hf);
    // each code 1 to 15 on a random terminal
    for (int c = 1; c < 16; c++) begin
      t = int'(xs() % 32'd6);
      ev = (c == 9) ? 32'h1 : (c == 7) ? 32'h2 : (c == 6) ? 32'h8 : 32'h0;
      wr(fa(t), 32'(c));
      set_pins(6'(1 << t), c[0]);
      expect_cmd(19'h1 << (19 - c));
      set_pins(6'h00, 1'b0);
      expect_cmd(19'h0);
      rd(dinmap_pkg::OFF_IRQST, ev);
      check("irq_set", 32'(irq), 32'(ev != 0));
      wr(dinmap_pkg::OFF_IRQST, ev);
      @(negedge pclk);
      check("irq_clr", 32'(irq), 32'h0);
      wr(fa(t), 32'h0);
    end
    // step selector, terminal 0 given the top bit
    for (int i = 0; i < 4; i++) wr(fa(i), 32'(19 - i));
    repeat (4) begin
      p = 4'(xs());
      set_pins({2'b00, p}, p[1]);
      expect_cmd({15'h0, p[0], p[1], p[2], p[3]});
    end
    set_pins(6'h00, 1'b0);
    // dual terminal as pulse input, then as plain input
    wr(fa(4), 32'(dinmap_pkg::FN_FWD));
    wr(dinmap_pkg::OFF_DUALCFG, 32'h3);
    set_pins(6'h30, 1'b0);
    settle();
    check("pulse_cmd", 32'(drive_cmd), 32'h0);
    check("pulse_sel", 32'(pulse_sel), 32'h3);
    check("pulse_raw", 32'(pulse_raw), 32'h3);
    wr(dinmap_pkg::OFF_DUALCFG, 32'h0);
    expect_cmd(19'h40000);
    rd(dinmap_pkg::OFF_CMD, 32'h40000);
    rd(dinmap_pkg::OFF_STATUS, 32'h30);
    set_pins(6'h00, 1'b0);
    wr(fa(4), 32'h0);
    // two stages plus decode
    settle();
    set_pins(6'h04, 1'b0);
    repeat (4) @(negedge pclk);
    check("sync_early", 32'(drive_cmd), 32'h0);
    @(negedge pclk);
    check("sync_late", 32'(drive_cmd), 32'h2);
    set_pins(6'h00, 1'b0);
    // duplicate codes, masked then unmasked
    wr(dinmap_pkg::OFF_IRQMSK, 32'h0);
    wr(fa(0), 32'(dinmap_pkg::FN_REV));
    wr(fa(1), 32'(dinmap_pkg::FN_REV));
    settle();
    check("cfg_invalid", 32'(cfg_invalid), 32'h1);
    check("dup_cmd", 32'(drive_cmd), 32'h2000);
    check("irq_masked", 32'(irq), 32'h0);
    rd(dinmap_pkg::OFF_IRQST, 32'h4);
    wr(dinmap_pkg::OFF_IRQMSK, 32'h4);
    @(negedge pclk);
    check("irq_unmask", 32'(irq), 32'h1);
    wr(dinmap_pkg::OFF_IRQST, 32'hc);
    wr(fa(1), 32'h0);
    settle();
    check("irq_end", 32'(irq), 32'h0);
    check("cfg_ok", 32'(cfg_invalid), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
